/* bench/pafc_port_a_bench.sv */
// self-checking bench for the port a pin function controller
// assumes the controller alone, reached through its avalon-mm slave port
`timescale 1ns/1ps
module pafc_port_a_bench;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  pafc_pkg::pafc_mode_t i_mode = 3'b100;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  pafc_pkg::pafc_pin_t [15:0] o_pins;
  logic [15:0] mdl [64];
  logic [15:0] rv;
  int bad_count = 0;
  int num_checks = 0;
  localparam logic [5:0] MAPPED [13] = '{6'h06, 6'h0c, 6'h0e, 6'h14, 6'h16, 6'h18, 6'h1a, 6'h1c, 6'h26, 6'h2c,
    6'h34, 6'h38, 6'h3a};
  pafc_port_a u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_mode(i_mode), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_pins(o_pins));
  initial forever #25 i_clock = ~i_clock;
  // -----------------------------------------------------------------
  // expectation and comparison
  // -----------------------------------------------------------------
  // unmapped places get mask zero, so their model stays zero
  function automatic logic [15:0] wmask(input logic [5:0] a);
    case (a)
      6'h06: wmask = i_mode.reduced ? 16'h83ff : 16'hffff;
      6'h0c: wmask = i_mode.reduced ? 16'h400f : 16'h555f;
      6'h0e: wmask = 16'hfd75;
      6'h14, 6'h16, 6'h18, 6'h1a, 6'h1c, 6'h26, 6'h2c, 6'h34, 6'h38, 6'h3a: wmask = 16'hffff;
      default: wmask = 16'h0000;
    endcase
  endfunction
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input int p, input pafc_pkg::pafc_func_t f, input logic d);
    num_checks++;
    if (o_pins[p] !== {f, d}) begin
      bad_count++;
      $display("unexpected at %0t: pin %0d shows %h", $time, p, o_pins[p]);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // -----------------------------------------------------------------
  // bus, reset and random traffic
  // -----------------------------------------------------------------
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [1:0] b);
    int n;
    logic [15:0] lm;
    n = 0;
    lm = {{8{b[1]}}, {8{b[0]}}};
    @(posedge i_clock);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdata <= {16'($urandom), d};
    be <= {2'($urandom), b};
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    if (o_avs_waitrequest !== 1'b0) begin
      bad_count++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    rv = o_avs_readdata[15:0];
    @(posedge i_clock);
    rd <= 1'b0;
    wr <= 1'b0;
    if (w) mdl[a] = (mdl[a] & ~lm) | (d & wmask(a) & lm);
  endtask
  task automatic settle;
    @(posedge i_clock);
    #1;
  endtask
  task automatic do_reset(input pafc_pkg::pafc_mode_t m);
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    i_mode <= m;
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    foreach (mdl[k]) mdl[k] = 16'h0000;
    mdl[6'h0c] = m.extended ? 16'h4000 : 16'h0000;
  endtask
  task automatic run_random(input int n);
    logic [5:0] a;
    logic w;
    repeat (n) begin
      a = ($urandom % 2) ? MAPPED[$urandom % 13] : 6'($urandom);
      w = 1'($urandom);
      bus(w, a, 16'($urandom), 2'($urandom));
      if (!w) cmp_reg(rv, mdl[a]);
    end
  endtask
  initial begin
    #1000000;
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    end_sim;
  end
  initial begin
    void'($urandom(46));
    do_reset(3'b100);
    for (int a = 0; a < 64; a++) begin
      bus(1'b0, 6'(a), 16'h0000, 2'b11);
      cmp_reg(rv, mdl[a]);
    end
    run_random(150);
    bus(1'b1, 6'h06, 16'hffff, 2'b11);
    bus(1'b1, 6'h0c, 16'h5540, 2'b11);
    bus(1'b1, 6'h0e, 16'h0010, 2'b11);
    settle;
    cmp_pin(15, pafc_pkg::FN_CLOCK_OUT, 1'b0);
    cmp_pin(14, pafc_pkg::FN_READ_STROBE, 1'b0);
    cmp_pin(13, pafc_pkg::FN_WRITE_UPPER, 1'b0);
    cmp_pin(12, pafc_pkg::FN_WRITE_LOWER, 1'b0);
    cmp_pin(2, pafc_pkg::FN_SERIAL_CLOCK, 1'b1);
    cmp_pin(0, pafc_pkg::FN_GPIO, 1'b1);
    cmp_pin(11, pafc_pkg::FN_CHIP_SELECT, 1'b0);
    cmp_pin(10, pafc_pkg::FN_GPIO, 1'b1);
    bus(1'b1, 6'h06, 16'h0000, 2'b01);
    settle;
    cmp_pin(0, pafc_pkg::FN_GPIO, 1'b0);
    cmp_pin(8, pafc_pkg::FN_GPIO, 1'b1);
    do_reset(3'b000);
    bus(1'b0, 6'h0c, 16'h0000, 2'b11);
    cmp_reg(rv, 16'h0000);
    bus(1'b1, 6'h0c, 16'h5500, 2'b11);
    bus(1'b1, 6'h0e, 16'h8800, 2'b11);
    settle;
    cmp_pin(15, pafc_pkg::FN_CLOCK_OUT, 1'b0);
    cmp_pin(14, pafc_pkg::FN_GPIO, 1'b0);
    cmp_pin(13, pafc_pkg::FN_GPIO, 1'b0);
    cmp_pin(7, pafc_pkg::FN_GPIO, 1'b0);
    cmp_pin(5, pafc_pkg::FN_GPIO, 1'b0);
    do_reset(3'b110);
    bus(1'b0, 6'h0c, 16'h0000, 2'b11);
    cmp_reg(rv, 16'h4000);
    settle;
    cmp_pin(14, pafc_pkg::FN_READ_STROBE, 1'b0);
    cmp_pin(12, pafc_pkg::FN_WRITE_LOWER, 1'b0);
    cmp_pin(11, pafc_pkg::FN_CHIP_SELECT, 1'b0);
    do_reset(3'b101);
    bus(1'b1, 6'h06, 16'hffff, 2'b11);
    bus(1'b0, 6'h06, 16'h0000, 2'b11);
    cmp_reg(rv, 16'h83ff);
    bus(1'b1, 6'h0c, 16'hffff, 2'b11);
    bus(1'b0, 6'h0c, 16'h0000, 2'b11);
    cmp_reg(rv, 16'h400f);
    run_random(40);
    end_sim;
  end
endmodule

/* bench/pafc_port_a_sva.sv */
// checker for the port a function controller: bus handshake and pin outputs
// assumes it is bound to pafc_port_a and sees only that module's ports
`timescale 1ns/1ps
module pafc_port_a_sva (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire pafc_pkg::pafc_mode_t i_mode,
  input wire logic [pafc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire pafc_pkg::pafc_pin_t [pafc_pkg::NUM_PINS-1:0] o_pins
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire req = i_avs_read | i_avs_write;
  wire rd_ok = i_avs_read & !o_avs_waitrequest;
  wire up_wr = i_avs_write & !o_avs_waitrequest & (i_avs_address == 6'h0c) & i_avs_byteenable[1];
  // -----------------------------------------------------------------
  // handshake and register reads
  // -----------------------------------------------------------------
  // two cycles allowed only around the init edge after reset
  chk_wait_answer: assert property (req && o_avs_waitrequest |-> ##[1:2] !o_avs_waitrequest)
    else $error("request not answered in time");
  chk_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("answer held too long");
  chk_wait_cause: assert property (!o_avs_waitrequest |-> req) else $error("answer without request");
  chk_high_zero: assert property (rd_ok |-> o_avs_readdata[31:16] == 16'h0000) else $error("upper half not zero");
  chk_upper_resv: assert property (rd_ok && i_avs_address == 6'h0c |-> (o_avs_readdata[15:0] & 16'haaa0) == 16'h0)
    else $error("reserved control bits not zero");
  chk_dir_reduced: assert property (rd_ok && i_avs_address == 6'h06 && i_mode.reduced |->
    o_avs_readdata[14:10] == 5'h00) else $error("absent direction bits not zero");
  chk_up_reduced: assert property (rd_ok && i_avs_address == 6'h0c && i_mode.reduced |->
    (o_avs_readdata[15:0] & 16'h1550) == 16'h0) else $error("absent control bits not zero");
  // -----------------------------------------------------------------
  // pin outputs
  // -----------------------------------------------------------------
  for (genvar g = 0; g < pafc_pkg::NUM_PINS; g++) begin : g_pin
    chk_drive_func: assert property (o_pins[g].drive |->
      o_pins[g].func inside {pafc_pkg::FN_GPIO, pafc_pkg::FN_SERIAL_CLOCK}) else $error("pin driven in wrong function");
  end
  chk_single_chip: assert property (!i_mode.extended |-> o_pins[14].func == pafc_pkg::FN_GPIO &&
    o_pins[13].func == pafc_pkg::FN_GPIO && o_pins[12].func == pafc_pkg::FN_GPIO) else $error("strobe in single-chip");
  chk_clock_out: assert property (up_wr |-> ##2 o_pins[15].func ==
    ($past(i_avs_writedata[14], 2) ? pafc_pkg::FN_CLOCK_OUT : pafc_pkg::FN_GPIO)) else $error("pin 15 function wrong");
  cover property (up_wr);
  cover property (rd_ok && i_mode.reduced);
  cover property (o_pins[2].func == pafc_pkg::FN_SERIAL_CLOCK && o_pins[2].drive);
endmodule
bind pafc_port_a pafc_port_a_sva u_sva (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_mode(i_mode),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_pins(o_pins));

/* common/pafc_pkg.sv */
// port a pin function controller: shared constants and types
// assumes a 32-bit word-addressed avalon-mm slave port and one 20 MHz clock
package pafc_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam int unsigned NUM_REGS = 13;
  localparam logic [31:0] MAP_BASE = 32'hffff8380;
  // full byte addresses of the map; the bus word index is the distance from MAP_BASE
  localparam logic [31:0] REG_OFFSET [NUM_REGS] = '{
    32'hffff8386, 32'hffff838c, 32'hffff838e, 32'hffff8394, 32'hffff8396,
    32'hffff8398, 32'hffff839a, 32'hffff839c, 32'hffff83a6, 32'hffff83ac,
    32'hffff83b4, 32'hffff83b8, 32'hffff83ba};
  localparam int unsigned REG_DIR_A = 0;
  localparam int unsigned REG_FUNC_UP = 1;
  localparam int unsigned REG_FUNC_LO = 2;
  localparam int unsigned ADDR_W = 6;

  // writable bits per register; reserved bits hold zero
  localparam logic [15:0] REG_WMASK [NUM_REGS] = '{
    16'hffff, 16'h555f, 16'hfd75, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
  // bits with no pin behind them in the reduced-pin variant
  localparam logic [15:0] REG_RMASK [NUM_REGS] = '{
    16'h7c00, 16'h1550, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] FUNC_UP_RESET_EXT = 16'h4000;
  localparam logic [15:0] FUNC_UP_RESET_SC = 16'h0000;

  // -----------------------------------------------------------------
  // upper control field positions
  // -----------------------------------------------------------------
  localparam int unsigned PIN15_SEL = 14;
  localparam int unsigned PIN14_SEL = 12;
  localparam int unsigned PIN13_SEL = 10;
  localparam int unsigned PIN12_SEL = 8;
  localparam int unsigned PIN11_SEL = 6;
  localparam int unsigned PIN10_SEL = 4;
  localparam int unsigned PIN9_SEL_LO = 2;
  localparam int unsigned PIN8_SEL_LO = 0;
  // lower control field positions
  localparam int unsigned PIN7_SEL_LO = 14;
  localparam int unsigned PIN6_SEL_LO = 12;
  localparam int unsigned PIN5_SEL_LO = 10;
  localparam int unsigned PIN4_SEL = 8;
  localparam int unsigned PIN3_SEL = 6;
  localparam int unsigned PIN2_SEL_LO = 4;
  localparam int unsigned PIN1_SEL = 2;
  localparam int unsigned PIN0_SEL = 0;
  localparam int unsigned NUM_PINS = 16;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    FN_GPIO = 4'h0, FN_CLOCK_OUT = 4'h1, FN_READ_STROBE = 4'h2,
    FN_WRITE_UPPER = 4'h3, FN_WRITE_LOWER = 4'h4, FN_CHIP_SELECT = 4'h5,
    FN_TIMER_CLOCK = 4'h6, FN_IRQ = 4'h7, FN_SERIAL_CLOCK = 4'h8,
    FN_DMA_REQUEST = 4'h9, FN_SERIAL_DATA = 4'ha, FN_RESERVED = 4'hb
  } pafc_func_t;

  typedef struct packed {
    logic extended;     // extended mode (external bus), else single-chip
    logic rom_disabled; // on-chip rom invalid mode
    logic reduced;      // reduced-pin variant
  } pafc_mode_t;

  typedef struct packed {
    pafc_func_t func;
    logic drive;        // 1: pin driven as output by the port logic
  } pafc_pin_t;

endpackage

/* hw/pafc_port_a.sv */
// port a pin function controller: direction and function registers,
// the other port registers as plain storage, and the per-pin decode.
// assumes i_rst_n is the external power-on reset only; watchdog, standby
// and sleep never reach this block, so they cannot disturb its contents.
`timescale 1ns/1ps
module pafc_port_a (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire pafc_pkg::pafc_mode_t i_mode,
  input wire logic [pafc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output pafc_pkg::pafc_pin_t [pafc_pkg::NUM_PINS-1:0] o_pins
);

  // -----------------------------------------------------------------
  // bus handshake
  // -----------------------------------------------------------------
  logic init_q;
  logic wait_q;
  logic wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  wire logic req = i_avs_read | i_avs_write;
  // the edge at which the master sees waitrequest low
  wire logic accept = req & ~wait_q;
  wire logic do_write = accept & i_avs_write;
  // one wait cycle lets read data come from a flop; held off during init
  assign wait_d = init_q | ~(req & wait_q);

  wire logic [15:0] lane_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // -----------------------------------------------------------------
  // register array
  // -----------------------------------------------------------------
  logic [15:0] regs_q [pafc_pkg::NUM_REGS];
  logic [15:0] regs_d [pafc_pkg::NUM_REGS];
  logic [15:0] rd_word [pafc_pkg::NUM_REGS];
  logic [pafc_pkg::NUM_REGS-1:0] hit;

  genvar k;
  generate
    for (k = 0; k < pafc_pkg::NUM_REGS; k++) begin : g_reg
      localparam logic [pafc_pkg::ADDR_W-1:0] IDX =
        pafc_pkg::ADDR_W'(pafc_pkg::REG_OFFSET[k] - pafc_pkg::MAP_BASE);
      // absent pins stay read-only in the reduced variant
      wire logic [15:0] live_mask = pafc_pkg::REG_WMASK[k] &
        ~(i_mode.reduced ? pafc_pkg::REG_RMASK[k] : 16'h0000);
      wire logic [15:0] merged = (regs_q[k] & ~lane_mask) | (i_avs_writedata[15:0] & lane_mask);
      assign hit[k] = (i_avs_address == IDX);
      // reserved bits never store a one
      assign regs_d[k] = (do_write & hit[k]) ?
        ((merged & live_mask) | (regs_q[k] & ~live_mask & pafc_pkg::REG_WMASK[k])) : regs_q[k];
      assign rd_word[k] = hit[k] ? (regs_q[k] & live_mask) : 16'h0000;

      if (k == pafc_pkg::REG_FUNC_UP) begin : g_up
        // reset value picked from the sampled mode
        always_ff @(posedge i_clock or negedge i_rst_n) begin
          if (!i_rst_n) begin
            regs_q[k] <= pafc_pkg::REG_RESET;
          end else if (init_q) begin
            regs_q[k] <= i_mode.extended ? pafc_pkg::FUNC_UP_RESET_EXT : pafc_pkg::FUNC_UP_RESET_SC;
          end else begin
            regs_q[k] <= regs_d[k];
          end
        end
      end else begin : g_plain
        always_ff @(posedge i_clock or negedge i_rst_n) begin
          if (!i_rst_n) begin
            regs_q[k] <= pafc_pkg::REG_RESET;
          end else begin
            regs_q[k] <= regs_d[k];
          end
        end
      end
    end
  endgenerate

  // unmapped addresses read zero and ignore writes
  always_comb begin
    rdata_d = 32'h0000_0000;
    for (int i = 0; i < pafc_pkg::NUM_REGS; i++) begin
      rdata_d[15:0] = rdata_d[15:0] | rd_word[i];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_q <= 1'b1;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      init_q <= 1'b0;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;

  // -----------------------------------------------------------------
  // pin function decode
  // -----------------------------------------------------------------
  wire logic [15:0] dir = regs_q[pafc_pkg::REG_DIR_A];
  wire logic [15:0] up = regs_q[pafc_pkg::REG_FUNC_UP];
  wire logic [15:0] lo = regs_q[pafc_pkg::REG_FUNC_LO];
  // the rom-off override applies only in full variants; the single-chip override applies in all
  wire logic rom_off = i_mode.rom_disabled & ~i_mode.reduced;
  wire logic single = ~i_mode.extended;

  // bus pin: rom-off forces the bus function, single-chip forces gpio
  function automatic pafc_pkg::pafc_func_t bus_pin(input logic sel, input pafc_pkg::pafc_func_t fn,
                                                   input logic off, input logic sc);
    pafc_pkg::pafc_func_t r;
    r = pafc_pkg::FN_GPIO;
    if (sc) begin
      r = pafc_pkg::FN_GPIO;
    end else if (sel | off) begin
      r = fn;
    end
    return r;
  endfunction

  // two-bit field with gpio, timer clock, a third function and reserved
  function automatic pafc_pkg::pafc_func_t two_bit(input logic [1:0] sel, input pafc_pkg::pafc_func_t fn2,
                                                   input pafc_pkg::pafc_func_t fn3);
    pafc_pkg::pafc_func_t r;
    unique case (sel)
      2'h0: r = pafc_pkg::FN_GPIO;
      2'h1: r = pafc_pkg::FN_TIMER_CLOCK;
      2'h2: r = fn2;
      2'h3: r = fn3;
    endcase
    return r;
  endfunction

  pafc_pkg::pafc_func_t fn [pafc_pkg::NUM_PINS];

  // pin 15 from the upper register
  assign fn[15] = up[pafc_pkg::PIN15_SEL] ? pafc_pkg::FN_CLOCK_OUT : pafc_pkg::FN_GPIO;
  assign fn[14] = bus_pin(up[pafc_pkg::PIN14_SEL], pafc_pkg::FN_READ_STROBE, rom_off, single);
  assign fn[13] = bus_pin(up[pafc_pkg::PIN13_SEL], pafc_pkg::FN_WRITE_UPPER, rom_off, single);
  assign fn[12] = bus_pin(up[pafc_pkg::PIN12_SEL], pafc_pkg::FN_WRITE_LOWER, rom_off, single);
  assign fn[11] = bus_pin(up[pafc_pkg::PIN11_SEL], pafc_pkg::FN_CHIP_SELECT, rom_off, single);
  assign fn[10] = bus_pin(up[pafc_pkg::PIN10_SEL], pafc_pkg::FN_CHIP_SELECT, rom_off, single);
  assign fn[9] = two_bit(up[pafc_pkg::PIN9_SEL_LO +: 2], pafc_pkg::FN_IRQ, pafc_pkg::FN_RESERVED);
  assign fn[8] = two_bit(up[pafc_pkg::PIN8_SEL_LO +: 2], pafc_pkg::FN_IRQ, pafc_pkg::FN_RESERVED);
  // pins 7..0 from the lower register; chip selects drop to gpio in single-chip
  assign fn[7] = (single & lo[pafc_pkg::PIN7_SEL_LO + 1]) ? pafc_pkg::FN_GPIO :
    two_bit(lo[pafc_pkg::PIN7_SEL_LO +: 2], pafc_pkg::FN_CHIP_SELECT, pafc_pkg::FN_RESERVED);
  assign fn[6] = (single & lo[pafc_pkg::PIN6_SEL_LO + 1]) ? pafc_pkg::FN_GPIO :
    two_bit(lo[pafc_pkg::PIN6_SEL_LO +: 2], pafc_pkg::FN_CHIP_SELECT, pafc_pkg::FN_RESERVED);

  // serial clock pins: 01 serial clock, 10 dma request, 11 interrupt
  function automatic pafc_pkg::pafc_func_t sck_pin(input logic [1:0] sel, input logic sc_gpio);
    pafc_pkg::pafc_func_t r;
    unique case (sel)
      2'h0: r = pafc_pkg::FN_GPIO;
      2'h1: r = pafc_pkg::FN_SERIAL_CLOCK;
      2'h2: r = sc_gpio ? pafc_pkg::FN_GPIO : pafc_pkg::FN_DMA_REQUEST;
      2'h3: r = pafc_pkg::FN_IRQ;
    endcase
    return r;
  endfunction

  // dma request on pin 5 falls back to gpio in single-chip
  assign fn[5] = sck_pin(lo[pafc_pkg::PIN5_SEL_LO +: 2], single);
  assign fn[4] = lo[pafc_pkg::PIN4_SEL] ? pafc_pkg::FN_SERIAL_DATA : pafc_pkg::FN_GPIO;
  assign fn[3] = lo[pafc_pkg::PIN3_SEL] ? pafc_pkg::FN_SERIAL_DATA : pafc_pkg::FN_GPIO;
  assign fn[2] = sck_pin(lo[pafc_pkg::PIN2_SEL_LO +: 2], 1'b0);
  assign fn[1] = lo[pafc_pkg::PIN1_SEL] ? pafc_pkg::FN_SERIAL_DATA : pafc_pkg::FN_GPIO;
  assign fn[0] = lo[pafc_pkg::PIN0_SEL] ? pafc_pkg::FN_SERIAL_DATA : pafc_pkg::FN_GPIO;

  // -----------------------------------------------------------------
  // registered pin outputs
  // -----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < pafc_pkg::NUM_PINS; p++) begin : g_pin
      // direction applies to gpio and serial clock only
      wire logic drive_d = dir[p] &
        ((fn[p] == pafc_pkg::FN_GPIO) | (fn[p] == pafc_pkg::FN_SERIAL_CLOCK));
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_pins[p] <= '{func: pafc_pkg::FN_GPIO, drive: 1'b0};
        end else begin
          o_pins[p] <= '{func: fn[p], drive: drive_d};
        end
      end
    end
  endgenerate

endmodule
